// file: hw/aif_pkg.sv
package aif_pkg;
  // Converter and port widths
  localparam int unsigned ADC_W      = 10;
  localparam int unsigned ACC_W      = 32;
  localparam int unsigned NUM_IN     = 6;
  localparam int unsigned NUM_OUT    = 3;
  localparam int unsigned SHIFT_W    = 5;
  // Filter setting range: setting 17 gives 1 ms, each step doubles
  localparam logic [4:0]  FSET_MIN   = 5'h11;
  localparam logic [4:0]  FSET_MAX   = 5'h1F;
  localparam logic [4:0]  FSET_RST   = 5'h11;
  // Sample tick derived from the base time constant
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned TBASE_US   = 1000;
  localparam int unsigned TICK_DIV   = 44;  // 44 steps of 2^-6 halve the error
  localparam int unsigned TAU_CYC    = CLK_MHZ * TBASE_US;
  localparam int unsigned TICK_CYC   = TAU_CYC / TICK_DIV;
  // Weight shift at setting 17: alpha = 2^-6 per tick
  localparam logic [4:0]  SHIFT_BASE = 5'h06;
  localparam int unsigned FRAC_W     = 20;  // Covers the largest weight shift
  // Register byte offsets
  localparam logic [7:0]  OFS_FILT   = 8'h00;
  localparam logic [7:0]  OFS_MASK   = 8'h04;
  localparam logic [7:0]  OFS_EDGE   = 8'h08;
  localparam logic [7:0]  OFS_LEVEL  = 8'h0C;
  localparam logic [7:0]  OFS_VALUE  = 8'h10;
  // Field positions
  localparam int unsigned MASK_OUT_LSB = 8;
  localparam int unsigned LVL_OUT_LSB  = 8;
endpackage : aif_pkg

// file: hw/aif_filter_io.sv
// Operation
// - Step 0 to 1 gives output one minus half to the t over T.
// - Five time constants after a step output reaches 97 percent.
// - Ten time constants after a step output is within 99.9 percent.
// - Setting 17..31 gives 1 ms doubling per step up to 16 s.
// - Masked lines lose their driver function and become general purpose.
// - Masked inputs read as zero for record selection.
// - Masked input level stays readable by the host.
// - Each input and output chooses rising or falling edge switching.
// - Analogue input is a 10 bit converter sample over plus minus 10 V.
`timescale 1ns/1ps
module aif_filter_io
  import aif_pkg::*;
(
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [7:0]                 paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  input  wire logic [aif_pkg::ADC_W-1:0]  adc_sample_in,
  input  wire logic [aif_pkg::NUM_IN-1:0] pin_in,
  input  wire logic [aif_pkg::NUM_OUT-1:0] func_out_in,
  input  wire logic [aif_pkg::NUM_OUT-1:0] user_out_in,
  output logic      [aif_pkg::ADC_W-1:0]  filt_value_out,
  output logic      [aif_pkg::NUM_IN-1:0] func_in_out,
  output logic      [aif_pkg::NUM_IN-1:0] in_edge_out,
  output logic      [aif_pkg::NUM_OUT-1:0] pin_out
);
  import aif_pkg::*;

  localparam int unsigned TOT_W = ADC_W + FRAC_W;

  // Synchronisers for pins and converter word
  logic [NUM_IN-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic [ADC_W-1:0]  a1_q, a1_d, a2_q, a2_d;
  // Configuration
  logic [4:0]        fset_q, fset_d;
  logic [NUM_IN+NUM_OUT-1:0] mask_q, mask_d, edge_q, edge_d;
  // Filter state
  logic [TOT_W-1:0]  acc_q, acc_d;
  logic [ACC_W-1:0]  tick_q, tick_d;
  logic              tick;
  // Bus and outputs
  logic [31:0]       rdata_q, rdata_d;
  logic              ready_q, ready_d, err_q, err_d;
  logic [NUM_IN-1:0] fin_q, fin_d, edg_q, edg_d;
  logic [NUM_OUT-1:0] pout_q, pout_d;
  logic [ADC_W-1:0]  fv_q, fv_d;

  // Per-line polarity, masking and edge detection
  logic [NUM_IN-1:0] in_lvl, in_prev;
  logic [NUM_OUT-1:0] out_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      assign in_lvl[gi]  = s2_q[gi] ^ edge_q[gi];
      assign in_prev[gi] = s3_q[gi] ^ edge_q[gi];
      assign fin_d[gi]   = mask_q[gi] ? 1'b0 : in_lvl[gi];
      assign edg_d[gi]   = ~mask_q[gi] & in_lvl[gi] & ~in_prev[gi];
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign out_lvl[gi] = mask_q[NUM_IN+gi] ? user_out_in[gi]
                                                   : func_out_in[gi];
      assign pout_d[gi]  = out_lvl[gi] ^ edge_q[NUM_IN+gi];
    end
  endgenerate

  // Filter tick and recursive low pass update
  logic [4:0]       shift;
  logic [TOT_W-1:0] sample_ext;
  logic [TOT_W:0]   diff;
  always_comb begin
    tick   = (tick_q == ACC_W'(TICK_CYC - 1));
    tick_d = tick ? '0 : tick_q + 1'b1;
    shift  = SHIFT_BASE + (fset_q - FSET_MIN);
    sample_ext = {a2_q, {FRAC_W{1'b0}}};
    diff   = {1'b0, sample_ext} - {1'b0, acc_q};
    acc_d  = acc_q;
    if (tick) begin
      // Signed step of (x - y) / 2^shift; alpha = 2^-shift
      if (diff[TOT_W])
        acc_d = acc_q - TOT_W'((~diff[TOT_W-1:0] + 1'b1) >> shift);
      else
        acc_d = acc_q + TOT_W'(diff[TOT_W-1:0] >> shift);
    end
    fv_d = acc_q[TOT_W-1:FRAC_W];
  end

  // Register file access over APB
  logic acc_en, wr_en;
  always_comb begin
    acc_en  = psel_in & penable_in & ~ready_q;
    wr_en   = acc_en & pwrite_in;
    ready_d = acc_en;
    err_d   = 1'b0;
    rdata_d = '0;
    fset_d  = fset_q;
    mask_d  = mask_q;
    edge_d  = edge_q;
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    a1_d = adc_sample_in;
    a2_d = a1_q;
    if (acc_en) begin
      case (paddr_in)
        OFS_FILT: begin
          rdata_d = {27'h0, fset_q};
          if (wr_en && pwdata_in[4:0] >= FSET_MIN
              && pwdata_in[4:0] <= FSET_MAX)
            fset_d = pwdata_in[4:0];
        end
        OFS_MASK: begin
          // Output mask bits sit at the upper field from bit 8, two zero bits above the inputs
          rdata_d = 32'({mask_q[NUM_IN +: NUM_OUT],
                         {(MASK_OUT_LSB-NUM_IN){1'b0}}, mask_q[NUM_IN-1:0]});
          if (wr_en) mask_d = {pwdata_in[MASK_OUT_LSB +: NUM_OUT],
                               pwdata_in[NUM_IN-1:0]};
        end
        OFS_EDGE: begin
          rdata_d = 32'(edge_q);
          if (wr_en) edge_d = pwdata_in[NUM_IN+NUM_OUT-1:0];
        end
        OFS_LEVEL: begin
          rdata_d = 32'({pout_q, {(LVL_OUT_LSB-NUM_IN){1'b0}}, s2_q});
          err_d   = pwrite_in;
        end
        OFS_VALUE: begin
          rdata_d = 32'(fv_q);
          err_d   = pwrite_in;
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  // Register everything
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s1_q <= '0; s2_q <= '0; s3_q <= '0;
      a1_q <= '0; a2_q <= '0;
      fset_q <= FSET_RST;
      mask_q <= '0; edge_q <= '0;
      acc_q <= '0; tick_q <= '0;
      rdata_q <= '0; ready_q <= 1'b0; err_q <= 1'b0;
      fin_q <= '0; edg_q <= '0; pout_q <= '0; fv_q <= '0;
    end else begin
      s1_q <= s1_d; s2_q <= s2_d; s3_q <= s3_d;
      a1_q <= a1_d; a2_q <= a2_d;
      fset_q <= fset_d;
      mask_q <= mask_d; edge_q <= edge_d;
      acc_q <= acc_d; tick_q <= tick_d;
      rdata_q <= rdata_d; ready_q <= ready_d; err_q <= err_d;
      fin_q <= fin_d; edg_q <= edg_d; pout_q <= pout_d; fv_q <= fv_d;
    end
  end

  assign prdata_out     = rdata_q;
  assign pready_out     = ready_q;
  assign pslverr_out    = err_q;
  assign filt_value_out = fv_q;
  assign func_in_out    = fin_q;
  assign in_edge_out    = edg_q;
  assign pin_out        = pout_q;

  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Masking, filter setting range and filter hold checks
  a_mask_zero: assert property ((|mask_q[NUM_IN-1:0]) |=>
    (func_in_out & $past(mask_q[NUM_IN-1:0])) == '0)
    else $error("masked input reached selection");
  a_mask_edge: assert property ((|mask_q[NUM_IN-1:0]) |=>
    (in_edge_out & $past(mask_q[NUM_IN-1:0])) == '0)
    else $error("masked input produced an edge");
  a_set_range: assert property (fset_q >= FSET_MIN && fset_q <= FSET_MAX)
    else $error("filter setting out of range");
  a_filt_hold: assert property (!tick |=> acc_q == $past(acc_q))
    else $error("filter moved without tick");
  // Filter, tick, output mask, level read and polarity checks
  a_filt_rise: assert property (tick && sample_ext > acc_q |=>
    acc_q >= $past(acc_q))
    else $error("filter moved away from input");
  a_filt_fall: assert property (tick && sample_ext < acc_q |=>
    acc_q <= $past(acc_q) && acc_q >= $past(sample_ext))
    else $error("filter overshoot downward");
  a_filt_bound: assert property (tick && sample_ext > acc_q |=>
    acc_q <= $past(sample_ext))
    else $error("filter overshoot upward");
  a_tick_span: assert property (tick_q < ACC_W'(TICK_CYC))
    else $error("tick counter past its period");
  a_out_mask: assert property (mask_q[NUM_IN] && !edge_q[NUM_IN]
    |=> pin_out[0] == $past(user_out_in[0]))
    else $error("masked output not user driven");
  a_level_read: assert property (acc_en && !pwrite_in && paddr_in == OFS_LEVEL
    |=> prdata_out[NUM_IN-1:0] == $past(s2_q))
    else $error("level read mismatch");
  a_edge_pol: assert property (!mask_q[0] |=>
    func_in_out[0] == $past(s2_q[0] ^ edge_q[0]))
    else $error("edge polarity wrong");
  // Bus checks
  a_ready_once: assert property (pready_out |=> !pready_out)
    else $error("pready stuck");
  a_fset_write: assert property (wr_en && paddr_in == OFS_FILT
    && pwdata_in[4:0] >= FSET_MIN && pwdata_in[4:0] <= FSET_MAX
    |=> fset_q == $past(pwdata_in[4:0]))
    else $error("filter setting write lost");
  a_fset_keep: assert property (wr_en && paddr_in == OFS_FILT
    && (pwdata_in[4:0] < FSET_MIN || pwdata_in[4:0] > FSET_MAX)
    |=> $stable(fset_q))
    else $error("illegal filter setting taken");
  a_ro_write: assert property (wr_en && (paddr_in == OFS_LEVEL
    || paddr_in == OFS_VALUE) |=> pslverr_out && pready_out)
    else $error("read-only write not refused");

  c_tick: cover property (tick);
  c_mask_wr: cover property (wr_en && paddr_in == OFS_MASK);
  c_err: cover property (pslverr_out);
  c_edge: cover property (|in_edge_out);
endmodule : aif_filter_io

// file: dv/aif_far_end.sv
`timescale 1ns/1ps
// Stand-in for the converter and the switch contacts
module aif_far_end
  import aif_pkg::*;
(
  input  wire logic [0:0]                  clock_in,
  input  wire logic [aif_pkg::ADC_W-1:0]   code_in,
  input  wire logic [aif_pkg::NUM_IN-1:0]  sw_in,
  output logic      [aif_pkg::ADC_W-1:0]   adc_out,
  output logic      [aif_pkg::NUM_IN-1:0]  pin_out
);
  // Converter word and contact levels change after each rising edge
  always_ff @(posedge clock_in) begin
    adc_out <= code_in;
    pin_out <= sw_in;
  end
endmodule : aif_far_end

// file: dv/aif_filter_io_tb.sv
`timescale 1ns/1ps
module aif_filter_io_tb;
  import aif_pkg::*;
  logic               clk, rst_n, psel, pen, pwr, prdy, perr, er;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [ADC_W-1:0]   code, adc, filt;
  logic [NUM_IN-1:0]  sw, pins, fin, edg, acc;
  logic [NUM_OUT-1:0] fo, uo, po;
  int                 bad_count, total_checks;

  // Clock at 200 MHz
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  aif_far_end FAR (.clock_in(clk), .code_in(code), .sw_in(sw),
    .adc_out(adc), .pin_out(pins));
  aif_filter_io DUT (.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy),
    .pslverr_out(perr), .adc_sample_in(adc), .pin_in(pins),
    .func_out_in(fo), .user_out_in(uo), .filt_value_out(filt),
    .func_in_out(fin), .in_edge_out(edg), .pin_out(po));

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Exact comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // Comparison within a tolerance of 16 codes
  task automatic near(input logic [31:0] g, input real x);
    total_checks++;
    if ($isunknown(g) || g > x + 16.0 || g < x - 16.0) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, int'(x));
    end
  endtask : near
  // One APB transfer; waits for pready with no bound of its own
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask : apb

  // Watchdog at 0.45 ms, past the expected run of about 0.4 ms
  initial begin
    #450000;
    bad_count++;
    test_done;
  end
  // Main sequence
  initial begin
    rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 8'h00;
    pwdata = 32'h0; code = 10'h000; sw = 6'h00; fo = 3'h0; uo = 3'h0;
    bad_count = 0; total_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, OFS_FILT, 0); chk(rd, 32'h11);
    apb(1, OFS_FILT, 32'h10); apb(0, OFS_FILT, 0); chk(rd, 32'h11);
    apb(1, OFS_FILT, 32'h1F); apb(0, OFS_FILT, 0); chk(rd, 32'h1F);
    apb(1, OFS_FILT, 32'h11);
    apb(0, 8'h14, 0); chk(er, 1'b1);
    apb(1, OFS_LEVEL, 0); chk(er, 1'b1);
    sw <= 6'h2A; fo <= 3'h5; uo <= 3'h2;
    repeat (6) @(posedge clk);
    chk(fin, 6'h2A); chk(po, 3'h5);
    apb(1, OFS_MASK, 32'h102);
    apb(1, OFS_EDGE, 32'h88);
    apb(0, OFS_MASK, 0); chk(rd, 32'h102);
    apb(0, OFS_EDGE, 0); chk(rd, 32'h88);
    repeat (4) @(posedge clk);
    chk(fin, 6'h20); chk(po, 3'h6);
    apb(0, OFS_LEVEL, 0); chk(rd, 32'h62A);
    acc = 6'h00;
    sw <= 6'h23;
    // Collect edge pulses: bit 0 rises, bit 3 falls with inversion
    repeat (8) begin
      @(posedge clk);
      acc = acc | edg;
    end
    chk(acc, 6'h09);
    code <= 10'h3FF;
    repeat (80000) @(posedge clk);
    near(filt, 1023.0 * (1.0 - 0.5 ** (80000.0 / TAU_CYC)));
    apb(0, OFS_VALUE, 0);
    near(rd, 1023.0 * (1.0 - 0.5 ** (80000.0 / TAU_CYC)));
    test_done;
  end
endmodule : aif_filter_io_tb
